/* File: charger_pkg.sv */
// Shared constants and state encoding for the charger control logic.
// Assumes a single 200 MHz core clock; analog comparator results arrive as logic levels.
package charger_pkg;
    localparam int CLK_MHZ = 200;
    // Base tick of the safety timer clock, in microseconds
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    // Pre-charge timeout as a multiple of the programmed charge timeout
    localparam int PCHG_MULT = 1;
    localparam int TIMEOUT_W = 24;
    localparam logic [23:0] CHG_TIMEOUT_TICKS = 24'h00_0E10;
    localparam logic [1:0] STAT_PRECHG = 2'h3;
    localparam logic [1:0] STAT_FAST = 2'h1;
    localparam logic [1:0] STAT_DONE = 2'h2;
    localparam logic [1:0] STAT_OFF = 2'h0;

    typedef enum logic [4:0] {
        ST_STANDBY = 5'h01,
        ST_BEGIN = 5'h02,
        ST_CHARGING = 5'h04,
        ST_SUSPEND = 5'h08,
        ST_FAULT = 5'h10
    } mode_e;
endpackage

/* File: tick_if.sv */
// Carries the safety timer count enable, hold, clear and expiry flag between the top and the timer module.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
    logic count_en;
    logic hold;
    logic clear;
    logic expired;
    modport ctrl (output count_en, output hold, output clear, input expired);
    modport timer (input count_en, input hold, input clear, output expired);
endinterface
`default_nettype wire

/* File: precharge_timer.sv */
// Pre-charge safety timer: tick divider and timeout counter.
// Assumes clear has priority over counting and hold freezes both counters.
`timescale 1ns/1ps
`default_nettype none
module precharge_timer #(
    parameter int TICK_CYCLES = charger_pkg::TICK_CYCLES,
    parameter int TIMEOUT_W = charger_pkg::TIMEOUT_W
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [TIMEOUT_W-1:0] limit_i,
    tick_if.timer tk
);
    logic [31:0] div;
    logic tick;
    logic [TIMEOUT_W-1:0] count;

    assign tick = (div == 32'(TICK_CYCLES - 1));

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div <= '0;
        end else if (tk.clear) begin
            div <= '0;
        end else if (tk.count_en && !tk.hold) begin
            div <= tick ? '0 : div + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= '0;
        end else if (tk.clear) begin
            count <= '0;
        end else if (tk.count_en && !tk.hold && tick && !tk.expired) begin
            count <= count + 1'b1;
        end
    end

    assign tk.expired = (count >= limit_i) && (limit_i != '0);
endmodule
`default_nettype wire

/* File: charger_ctrl.sv */
// Charger control logic: qualification, status encoding, pre-charge timer and fault latch.
// Assumes comparator results and host pins are synchronous to core_clk_i.
//
// Summary of operation
// - Temperature out of window suspends, timers held
// - Temperature back in window resumes charging
// - Power good low only without overvoltage
// - Overvoltage turns charger off, standby mode
// - Overvoltage not latched, recovers automatically
// - Status pins encode charge state
// - Termination disabled never reports done
// - Fast current above threshold, precharge below
// - Voltage regulation at regulation voltage
// - Pre-charge timer runs only during preconditioning
// - Timer counts, holds or resets by mode
// - Timeout below threshold sets fault, charger off
// - Fault with power below threshold: recovery current
// - Output above threshold clears fault latch
// - Enable rise, overvoltage, power loss clear fault
`timescale 1ns/1ps
`default_nettype none
module charger_ctrl #(
    parameter int TICK_CYCLES = charger_pkg::TICK_CYCLES,
    parameter int PCHG_MULT = charger_pkg::PCHG_MULT
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic charge_enable_n_i,
    input wire logic input_detect_i,
    input wire logic input_overvoltage_i,
    input wire logic pack_temp_sense_ok_i,
    input wire logic below_precharge_threshold_i,
    input wire logic at_regulation_voltage_i,
    input wire logic timer_program_open_i,
    input wire logic finish_allow_n_i,
    input wire logic termination_done_i,
    input wire logic battery_absent_i,
    input wire logic battery_short_i,
    input wire logic [charger_pkg::TIMEOUT_W-1:0] charge_timeout_i,
    output logic power_stage_on_o,
    output logic fast_current_sel_o,
    output logic precharge_current_sel_o,
    output logic voltage_regulation_o,
    output logic recovery_current_o,
    output logic precharge_fault_o,
    output logic power_good_n_o,
    output logic power_good_n_oe_o,
    output logic status_a_o,
    output logic status_a_oe_o,
    output logic status_b_o,
    output logic status_b_oe_o
);
    logic ce_n;
    logic in_det;
    logic input_overvoltage;
    logic temp_ok;
    logic below;
    logic at_reg;
    logic tmr_open;
    logic term_off_n;
    logic done_in;
    logic bat_absent;
    logic bat_short;
    logic ce_n_prev;
    logic fault;
    logic next_fault;
    logic [charger_pkg::TIMEOUT_W-1:0] limit;
    charger_pkg::mode_e mode;
    charger_pkg::mode_e next_mode;
    logic [1:0] stat;
    logic term_disabled;
    logic power_ok;
    tick_if tk();

    // Single-bit inputs registered once into one consistent snapshot; charge_timeout_i sets the timer limit unregistered
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ce_n <= 1'b1;
            in_det <= 1'b0;
            input_overvoltage <= 1'b0;
            temp_ok <= 1'b0;
            below <= 1'b1;
            at_reg <= 1'b0;
            tmr_open <= 1'b0;
            term_off_n <= 1'b1;
            done_in <= 1'b0;
            bat_absent <= 1'b0;
            bat_short <= 1'b0;
        end else begin
            ce_n <= charge_enable_n_i;
            in_det <= input_detect_i;
            input_overvoltage <= input_overvoltage_i;
            temp_ok <= pack_temp_sense_ok_i;
            below <= below_precharge_threshold_i;
            at_reg <= at_regulation_voltage_i;
            tmr_open <= timer_program_open_i;
            term_off_n <= finish_allow_n_i;
            done_in <= termination_done_i;
            bat_absent <= battery_absent_i;
            bat_short <= battery_short_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ce_n_prev <= 1'b1;
        end else begin
            ce_n_prev <= ce_n;
        end
    end

    assign power_ok = in_det && !input_overvoltage;
    assign term_disabled = tmr_open || term_off_n;

    always_comb begin
        next_mode = mode;
        case (mode)
            charger_pkg::ST_STANDBY: begin
                if (power_ok && !ce_n) begin
                    next_mode = charger_pkg::ST_BEGIN;
                end
            end
            charger_pkg::ST_BEGIN: begin
                next_mode = charger_pkg::ST_CHARGING;
            end
            charger_pkg::ST_CHARGING: begin
                if (fault || tk.expired && below) begin
                    next_mode = charger_pkg::ST_FAULT;
                end else if (!temp_ok) begin
                    next_mode = charger_pkg::ST_SUSPEND;
                end
            end
            charger_pkg::ST_SUSPEND: begin
                if (temp_ok) begin
                    next_mode = charger_pkg::ST_CHARGING;
                end
            end
            charger_pkg::ST_FAULT: begin
                if (!fault) begin
                    next_mode = charger_pkg::ST_BEGIN;
                end
            end
            default: begin
                next_mode = charger_pkg::ST_STANDBY;
            end
        endcase
        // Enable high, power loss or overvoltage force standby from anywhere
        if (ce_n || !power_ok) begin
            next_mode = charger_pkg::ST_STANDBY;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode <= charger_pkg::ST_STANDBY;
        end else begin
            mode <= next_mode;
        end
    end

    // Timer control: count only while precharging with a programmed timer
    assign tk.clear = (mode == charger_pkg::ST_STANDBY) || (mode == charger_pkg::ST_BEGIN)
        || !below || tmr_open;
    assign tk.count_en = (mode == charger_pkg::ST_CHARGING) && below && !tmr_open;
    assign tk.hold = (mode == charger_pkg::ST_SUSPEND) && below;

    // Pre-charge timeout is a fixed multiple of the charge timeout
    assign limit = charger_pkg::TIMEOUT_W'(charge_timeout_i * PCHG_MULT);

    precharge_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .TIMEOUT_W(charger_pkg::TIMEOUT_W)
    ) u_timer (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .limit_i(limit),
        .tk(tk)
    );

    // Setting wins over clearing so a timeout coinciding with a clear is kept
    always_comb begin
        next_fault = fault;
        if ((ce_n && !ce_n_prev) || input_overvoltage || !in_det || tmr_open || !below) begin
            next_fault = 1'b0;
        end
        if (tk.count_en && tk.expired && below) begin
            next_fault = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault <= 1'b0;
        end else begin
            fault <= next_fault;
        end
    end

    always_comb begin
        stat = charger_pkg::STAT_OFF;
        if (mode == charger_pkg::ST_CHARGING && !bat_absent && !bat_short) begin
            if (done_in && !term_disabled) begin
                stat = charger_pkg::STAT_DONE;
            end else if (below) begin
                stat = charger_pkg::STAT_PRECHG;
            end else begin
                stat = charger_pkg::STAT_FAST;
            end
        end
        if (fault) begin
            stat = charger_pkg::STAT_OFF;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            power_stage_on_o <= 1'b0;
            fast_current_sel_o <= 1'b0;
            precharge_current_sel_o <= 1'b0;
            voltage_regulation_o <= 1'b0;
            recovery_current_o <= 1'b0;
            precharge_fault_o <= 1'b0;
            power_good_n_oe_o <= 1'b0;
            status_a_oe_o <= 1'b0;
            status_b_oe_o <= 1'b0;
        end else begin
            power_stage_on_o <= (mode == charger_pkg::ST_CHARGING) && !fault
                && !(done_in && !term_disabled);
            fast_current_sel_o <= (mode == charger_pkg::ST_CHARGING) && !below;
            precharge_current_sel_o <= (mode == charger_pkg::ST_CHARGING) && below;
            voltage_regulation_o <= (mode == charger_pkg::ST_CHARGING) && at_reg;
            recovery_current_o <= fault && in_det && below;
            precharge_fault_o <= fault;
            power_good_n_oe_o <= power_ok;
            status_a_oe_o <= stat[0];
            status_b_oe_o <= stat[1];
        end
    end

    // Open-collector pins only ever pull low
    assign power_good_n_o = 1'b0;
    assign status_a_o = 1'b0;
    assign status_b_o = 1'b0;
endmodule
`default_nettype wire

/* File: status_host_model.sv */
// Host side of the open-collector status pins: pull-ups seen by a host or LEDs.
// Assumes oe high means the device sinks the pin to its data level.
`timescale 1ns/1ps
`default_nettype none
module status_host_model (
    input wire logic [2:0] d_i,
    input wire logic [2:0] oe_i,
    output logic [2:0] pins_o
);
    // A released pin floats up to the pull-up level, never keeps its last value
    assign pins_o = (d_i & oe_i) | ~oe_i;
endmodule
`default_nettype wire

/* File: charger_ctrl_assertions.sv */
// Concurrent checks on the charger control ports.
// Bound into charger_ctrl; outputs settle two to five edges after an input change.
`timescale 1ns/1ps
`default_nettype none
module charger_ctrl_assertions #(
    parameter int TICK_CYCLES = 4,
    parameter int PCHG_MULT = 1
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic charge_enable_n_i,
    input wire logic input_detect_i,
    input wire logic input_overvoltage_i,
    input wire logic pack_temp_sense_ok_i,
    input wire logic below_precharge_threshold_i,
    input wire logic finish_allow_n_i,
    input wire logic power_stage_on_o,
    input wire logic fast_current_sel_o,
    input wire logic recovery_current_o,
    input wire logic precharge_fault_o,
    input wire logic power_good_n_oe_o,
    input wire logic status_a_oe_o,
    input wire logic status_b_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_pg_when_ok: assert property ((input_detect_i && !input_overvoltage_i)[*3] |=> power_good_n_oe_o)
        else $error("power good not driven");
    a_ovp_stage_off: assert property (input_overvoltage_i[*3] |=> !power_stage_on_o)
        else $error("stage on during overvoltage");
    a_temp_suspend: assert property (!pack_temp_sense_ok_i[*3] |=> !power_stage_on_o)
        else $error("stage on with bad temperature");
    a_no_done_code: assert property (finish_allow_n_i[*4] |=> !(status_b_oe_o && !status_a_oe_o))
        else $error("done shown with termination off");
    a_below_no_fast: assert property (below_precharge_threshold_i[*3] |=> !fast_current_sel_o)
        else $error("fast current below threshold");
    a_fault_stage_off: assert property (precharge_fault_o[*3] |-> !power_stage_on_o)
        else $error("stage on during fault");
    a_recovery_cause: assert property (recovery_current_o |-> precharge_fault_o || $past(precharge_fault_o))
        else $error("recovery current without fault");
    a_fault_blanks_status: assert property (precharge_fault_o[*3] |-> !status_a_oe_o && !status_b_oe_o)
        else $error("status not off during fault");
    a_enable_rise_clears: assert property ($rose(charge_enable_n_i) |-> ##[1:4] !precharge_fault_o)
        else $error("fault kept after enable rise");
    cover property (precharge_fault_o && recovery_current_o);
    cover property (status_b_oe_o && !status_a_oe_o);
    cover property ($rose(power_good_n_oe_o));
endmodule
bind charger_ctrl charger_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES), .PCHG_MULT(PCHG_MULT))
    charger_ctrl_assertions_inst (.*);
`default_nettype wire

/* File: test_charger_status_precharge_timer.sv */
// Self-checking bench for the charger control block with a pulled-up status host.
// Assumes a short timer tick so pre-charge timeouts take tens of cycles.
`timescale 1ns/1ps
`default_nettype none
module test_charger_status_precharge_timer;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_n = 1'b1, det = 1'b1, input_overvoltage = 1'b0, temp_ok = 1'b1, below = 1'b1, at_reg = 1'b0;
    logic t_open = 1'b0, fin_n = 1'b0, done = 1'b0;
    logic bat_abs = 1'b0, bat_sh = 1'b0;
    logic [23:0] tmo = 24'h000004;
    logic stage, fast, pre, rec, fault, vreg;
    logic [2:0] d, oe, pins;
    logic [15:0] notes[$];
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    event look;
    always #2.5 core_clk_i = ~core_clk_i;
    charger_ctrl #(.TICK_CYCLES(4), .PCHG_MULT(1)) charger_ctrl_inst (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .charge_enable_n_i(ce_n),
        .input_detect_i(det), .input_overvoltage_i(input_overvoltage), .pack_temp_sense_ok_i(temp_ok),
        .below_precharge_threshold_i(below), .at_regulation_voltage_i(at_reg),
        .timer_program_open_i(t_open), .finish_allow_n_i(fin_n), .termination_done_i(done),
        .battery_absent_i(bat_abs), .battery_short_i(bat_sh), .charge_timeout_i(tmo),
        .power_stage_on_o(stage), .fast_current_sel_o(fast), .precharge_current_sel_o(pre),
        .voltage_regulation_o(vreg), .recovery_current_o(rec), .precharge_fault_o(fault),
        .power_good_n_o(d[2]), .power_good_n_oe_o(oe[2]), .status_a_o(d[1]),
        .status_a_oe_o(oe[1]), .status_b_o(d[0]), .status_b_oe_o(oe[0]));
    status_host_model status_host_model_inst (.d_i(d), .oe_i(oe), .pins_o(pins));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Settle one edge past the slowest, five-edge response before noting the expectation
    task automatic expect_now(input logic [7:0] mask, input logic [7:0] exp);
        repeat (6) @(negedge core_clk_i);
        notes.push_back({mask, exp});
        ->look;
    endtask
    task automatic wait_fault();
        int i;
        for (i = 0; i < 400 && fault !== 1'b1; i++) @(negedge core_clk_i);
    endtask
    always @(look) begin
        logic [15:0] n;
        n = notes.pop_front();
        check({stage, fast, pre, rec, fault, pins} & n[15:8], n[7:0]);
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(45));
        tmo = 24'(4 + $urandom % 4);
        repeat (10) @(negedge core_clk_i);
        expect_now(8'hFF, 8'h07);
        rstn_i = 1'b1;
        ce_n = 1'b0;
        expect_now(8'hFF, 8'hA0);
        wait_fault();
        expect_now(8'hFF, 8'h1B);
        below = 1'b0;
        expect_now(8'hFF, 8'hC1);
        temp_ok = 1'b0;
        expect_now(8'hFF, 8'h03);
        temp_ok = 1'b1;
        expect_now(8'hFF, 8'hC1);
        bat_abs = 1'b1;
        expect_now(8'h07, 8'h03);
        bat_abs = 1'b0;
        bat_sh = 1'b1;
        expect_now(8'h07, 8'h03);
        bat_sh = 1'b0;
        expect_now(8'hFF, 8'hC1);
        done = 1'b1;
        at_reg = 1'b1;
        expect_now(8'h07, 8'h02);
        check({7'h00, vreg}, 8'h01);
        fin_n = 1'b1;
        expect_now(8'h07, 8'h01);
        done = 1'b0;
        fin_n = 1'b0;
        at_reg = 1'b0;
        input_overvoltage = 1'b1;
        expect_now(8'hFF, 8'h07);
        input_overvoltage = 1'b0;
        expect_now(8'hFF, 8'hC1);
        det = 1'b0;
        expect_now(8'hFF, 8'h07);
        det = 1'b1;
        below = 1'b1;
        expect_now(8'hFF, 8'hA0);
        wait_fault();
        expect_now(8'hFF, 8'h1B);
        // Open timer pin clears the fault and charging restarts untimed
        t_open = 1'b1;
        expect_now(8'hFF, 8'hA0);
        t_open = 1'b0;
        wait_fault();
        expect_now(8'hFF, 8'h1B);
        ce_n = 1'b1;
        expect_now(8'hFF, 8'h03);
        repeat (2) @(negedge core_clk_i);
        wrap_up();
    end
endmodule
`default_nettype wire
